// File: flash_seq.sv
// Serial flash program and erase sequencer with serial-clock front end
//
// Summary of operation
// - Page write stores 1 to 256 bytes into one page in arrival order.
// - Page write aimed at a protected page is ignored, memory untouched.
// - Programming starts on select rise; a partial last byte discards it.
// - While programming, every instruction is ignored.
// - Pending flag reads 1 during program or erase, 0 when done.
// - Over 256 bytes wrap in the page; only the final 256 are kept.
// - Start anywhere in a page; past its end the address wraps to start.
// - Bytes not sent keep their stored value.
// - Programming only clears bits; erasure alone sets them again.
// - Small wipe clears a 4 KB sector, or the addressed 1 KB subsector in sector 0 when enabled and density is not 512K.
// - Small wipe is opcode plus three address bytes; starts on select rise.
// - Wipes need the permit latch; the latch clears when the wipe ends.
// - Large wipe clears 32 KB on small densities, 64 KB on large ones.
// - Large wipe is opcode plus three address bytes; starts on select rise.
// - Full wipe is the opcode alone and clears the whole array.
// - During any wipe every instruction is rejected.
// - Blocks span eight sectors on small densities, sixteen on large.
// - Subsectors start at 0x000000, 0x000400, 0x000800 and 0x000c00.
// - Small wipe touches only its own sector; no pre-programming needed.
// - Opcodes 0x02 write, 0xd7 small, 0xd8 large, 0xc7 full wipe.
// - Serial input bits are sampled on the serial clock rising edge.
// - The permit latch is cleared after reset.
`timescale 1ns/100ps
`default_nettype none
module flash_seq
    import flash_seq_pkg::*;
#(
    parameter int         PROG_CYC      = PROG_CYCLES,
    parameter int         ERASE_CYC     = ERASE_CYCLES,
    parameter logic [7:0] PERMIT_OPC    = 8'h06,
    parameter logic [7:0] REVOKE_OPC    = 8'h04
)(
    // System
    input  wire logic     clk,
    input  wire logic     rst,
    // Serial link
    input  wire logic     sck,
    input  wire logic     cs_n,
    input  wire logic     si,
    // Configuration
    input  wire density_t density,
    input  wire logic     subsector_en,
    input  wire logic     protect_level_bit2,
    input  wire logic     protect_level_bit1,
    input  wire logic     protect_level_bit0,
    // Status
    output logic          write_permit_latch,
    output logic          operation_pending_flag,
    // Array port
    output arr_cmd_t      arr_cmd
);

    // ****************************************
    // Helper functions
    // ****************************************
    function automatic logic [18:0] dens_mask(input density_t d);
        unique case (d)
            DENS_512K: return MASK_512K;
            DENS_1M:   return MASK_1M;
            DENS_2M:   return MASK_2M;
            DENS_4M:   return MASK_4M;
        endcase
    endfunction

    // True when any byte up to last lies inside the read-only top area
    function automatic logic prot_hit(input logic [18:0] last, input density_t d,
                                      input logic [2:0] bp);
        logic [19:0] size;
        logic [19:0] lo;
        size = {1'b0, dens_mask(d)} + 20'h1;
        lo   = (bp == 3'h0) ? size : size - (size >> (3'h7 - bp));
        return ({1'b0, last} >= lo);
    endfunction

    // ****************************************
    // Serial clock domain
    // ****************************************
    logic       armed, byte_tgl, partial;
    logic [2:0] bit_cnt, next_bit_cnt;
    logic [6:0] shift;
    logic [7:0] byte_hold;

    // Select high ends the frame without needing a serial edge
    always_ff @(posedge sck or posedge rst or posedge cs_n)
        if (rst || cs_n)
            armed <= 1'b1;
        else
            armed <= 1'b0;

    assign next_bit_cnt = armed ? 3'h1 : bit_cnt + 3'h1;

    always_ff @(posedge sck or posedge rst)
        if (rst)
        begin
            bit_cnt <= 3'h0;
            partial <= 1'b0;
            shift   <= 7'h00;
        end
        else
        begin
            bit_cnt <= next_bit_cnt;
            partial <= (next_bit_cnt != 3'h0);
            shift   <= {shift[5:0], si};
        end

    // Whole byte is held stable for the next seven serial edges
    always_ff @(posedge sck or posedge rst)
        if (rst)
        begin
            byte_hold <= 8'h00;
            byte_tgl  <= 1'b0;
        end
        else if (!armed && bit_cnt == 3'h7)
        begin
            byte_hold <= {shift, si};
            byte_tgl  <= ~byte_tgl;
        end

    // ****************************************
    // Crossing into the system clock
    // ****************************************
    logic [2:0] sync1, sync2, sync3, stable, stable_d;
    logic       cs_fall, cs_rise, cs_rise_d, byte_evt;

    // Bit 0 select, bit 1 byte toggle, bit 2 partial-byte flag
    always_ff @(posedge clk or posedge rst)
        if (rst)
        begin
            sync1    <= SYNC_RESET;
            sync2    <= SYNC_RESET;
            sync3    <= SYNC_RESET;
            stable   <= SYNC_RESET;
            stable_d <= SYNC_RESET;
        end
        else
        begin
            sync1    <= {partial, byte_tgl, cs_n};
            sync2    <= sync1;
            sync3    <= sync2;
            stable   <= (~(sync2 ^ sync3) & sync3) | ((sync2 ^ sync3) & stable);
            stable_d <= stable;
        end

    assign cs_fall  = stable_d[0] && !stable[0];
    assign cs_rise  = !stable_d[0] && stable[0];
    assign byte_evt = stable_d[1] ^ stable[1];

    // Rise acted on a cycle late; a last byte seen in the rise cycle is gated off by select high and dropped
    always_ff @(posedge clk or posedge rst)
        if (rst)
            cs_rise_d <= 1'b0;
        else
            cs_rise_d <= cs_rise;

    // ****************************************
    // Frame capture
    // ****************************************
    seq_state_t  state;
    logic        frame_ok;
    logic [2:0]  byte_cnt;
    logic [7:0]  opcode;
    logic [23:0] addr;
    logic [7:0]  wptr;
    logic [255:0] vmask;
    logic [7:0]  page_buf [256];
    logic        take_data;

    assign take_data = frame_ok && !stable[0] && byte_evt && byte_cnt == ADDR_BYTES_END
                       && opcode == OPC_PAGE_WRITE;

    always_ff @(posedge clk or posedge rst)
        if (rst)
        begin
            frame_ok <= 1'b0;
            byte_cnt <= 3'h0;
            opcode   <= 8'h00;
            addr     <= 24'h000000;
            wptr     <= 8'h00;
            vmask    <= '0;
        end
        else if (cs_fall)
        begin
            frame_ok <= (state == ST_IDLE);
            byte_cnt <= 3'h0;
            if (state == ST_IDLE)
                vmask <= '0;
        end
        else if (frame_ok && !stable[0] && byte_evt)
        begin
            if (byte_cnt != ADDR_BYTES_END)
                byte_cnt <= byte_cnt + 3'h1;
            unique case (byte_cnt)
                3'h0:    opcode <= byte_hold;
                3'h1:    addr[23:16] <= byte_hold;
                3'h2:    addr[15:8] <= byte_hold;
                3'h3:
                begin
                    addr[7:0] <= byte_hold;
                    wptr      <= byte_hold;
                end
                default:
                begin
                    if (take_data)
                    begin
                        vmask[wptr] <= 1'b1;
                        wptr        <= wptr + 8'h1;
                    end
                end
            endcase
        end

    // Later bytes overwrite earlier ones at the same offset
    always_ff @(posedge clk)
        if (take_data)
            page_buf[wptr] <= byte_hold;

    // ****************************************
    // Instruction decode at frame end
    // ****************************************
    logic        start_go, prog_ok, erase_ok, is_erase;
    logic [2:0]  bp;
    logic [18:0] span, base, page_base;

    assign bp        = {protect_level_bit2, protect_level_bit1, protect_level_bit0};
    assign start_go  = cs_rise_d && frame_ok && !stable[2];
    assign page_base = addr[18:0] & dens_mask(density) & ~SPAN_PAGE;

    always_comb
    begin
        span     = SPAN_SECTOR;
        is_erase = 1'b0;
        if (opcode == OPC_SMALL_WIPE && byte_cnt == ADDR_BYTES_END)
        begin
            is_erase = 1'b1;
            if (subsector_en && density != DENS_512K && (page_base & ~SPAN_SECTOR) == 19'h00000)
                span = SPAN_SUBSECTOR;
        end
        else if (opcode == OPC_LARGE_WIPE && byte_cnt == ADDR_BYTES_END)
        begin
            is_erase = 1'b1;
            span = (density == DENS_512K || density == DENS_1M)
                   ? SPAN_BLOCK_32K : SPAN_BLOCK_64K;
        end
        else if (opcode == OPC_FULL_WIPE && byte_cnt == OPC_ONLY_BYTES)
        begin
            is_erase = 1'b1;
            span = dens_mask(density);
        end
    end

    assign base     = addr[18:0] & dens_mask(density) & ~span;
    // Incomplete address leaves byte_cnt short, so nothing below matches
    assign prog_ok  = opcode == OPC_PAGE_WRITE && byte_cnt == ADDR_BYTES_END
                      && vmask != '0 && write_permit_latch
                      && !prot_hit(page_base | SPAN_PAGE, density, bp);
    assign erase_ok = is_erase && write_permit_latch
                      && !prot_hit(base | span, density, bp);

    // ****************************************
    // Operation sequencer
    // ****************************************
    logic [TIMER_W-1:0] timer;
    logic [8:0]         scan;
    logic [18:0]        op_base;
    logic [18:0]        op_span;

    always_ff @(posedge clk or posedge rst)
        if (rst)
        begin
            state                  <= ST_IDLE;
            timer                  <= '0;
            scan                   <= 9'h000;
            op_base                <= 19'h00000;
            op_span                <= 19'h00000;
            write_permit_latch     <= PERMIT_RESET;
            operation_pending_flag <= 1'b0;
            arr_cmd                <= '0;
        end
        else
        begin
            arr_cmd <= '0;
            if (state != ST_IDLE && timer != '0)
                timer <= timer - 1'b1;
            unique case (state)
                ST_IDLE:
                begin
                    if (start_go && opcode == PERMIT_OPC && byte_cnt == OPC_ONLY_BYTES)
                        write_permit_latch <= 1'b1;
                    else if (start_go && opcode == REVOKE_OPC && byte_cnt == OPC_ONLY_BYTES)
                        write_permit_latch <= 1'b0;
                    else if (start_go && prog_ok)
                    begin
                        state                  <= ST_PROG;
                        timer                  <= TIMER_W'(PROG_CYC - 1);
                        scan                   <= 9'h000;
                        op_base                <= page_base;
                        operation_pending_flag <= 1'b1;
                    end
                    else if (start_go && erase_ok)
                    begin
                        state                  <= ST_ERASE;
                        timer                  <= TIMER_W'(ERASE_CYC - 1);
                        op_base                <= base;
                        op_span                <= span;
                        operation_pending_flag <= 1'b1;
                    end
                end
                ST_PROG:
                begin
                    // Only bytes that arrived are sent; array ANDs data in
                    if (vmask[scan[7:0]])
                    begin
                        arr_cmd.valid <= 1'b1;
                        arr_cmd.erase <= 1'b0;
                        arr_cmd.addr  <= op_base | {11'h000, scan[7:0]};
                        arr_cmd.span  <= 19'h00000;
                        arr_cmd.data  <= page_buf[scan[7:0]];
                    end
                    scan <= scan + 9'h001;
                    if (scan == PAGE_LAST)
                        state <= ST_WAIT;
                end
                ST_ERASE:
                begin
                    arr_cmd.valid <= 1'b1;
                    arr_cmd.erase <= 1'b1;
                    arr_cmd.addr  <= op_base;
                    arr_cmd.span  <= op_span;
                    arr_cmd.data  <= 8'hff;
                    state         <= ST_WAIT;
                end
                ST_WAIT:
                begin
                    if (timer == '0)
                    begin
                        state                  <= ST_IDLE;
                        operation_pending_flag <= 1'b0;
                        write_permit_latch     <= 1'b0;
                    end
                end
            endcase
        end

    // ****************************************
    // Checks
    // ****************************************
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    sequence s_prog_start;
        state == ST_IDLE ##1 state == ST_PROG;
    endsequence

    sequence s_erase_start;
        state == ST_IDLE ##1 state == ST_ERASE;
    endsequence

    chk_pending_busy: assert property (state != ST_IDLE |-> operation_pending_flag)
        else $error("pending flag low during operation");
    chk_pending_idle: assert property ($fell(operation_pending_flag) |->
                                       state == ST_IDLE && $past(timer) == '0)
        else $error("pending flag fell before timer expiry");
    chk_prog_permit: assert property (s_prog_start |-> $past(write_permit_latch, 2))
        else $error("program started without permit latch");
    chk_erase_permit: assert property (s_erase_start |-> $past(write_permit_latch, 2))
        else $error("erase started without permit latch");
    chk_permit_clear: assert property (state == ST_WAIT && timer == '0
                                       |=> !write_permit_latch)
        else $error("permit latch not cleared at completion");
    chk_partial_drop: assert property (cs_rise_d && stable[2] && state == ST_IDLE
                                       |=> state == ST_IDLE)
        else $error("partial byte frame started an operation");
    chk_busy_ignore: assert property (cs_fall && state != ST_IDLE |=> !frame_ok)
        else $error("frame accepted while busy");
    chk_page_stay: assert property (arr_cmd.valid && !arr_cmd.erase
                                    |-> arr_cmd.addr[18:8] == op_base[18:8])
        else $error("program byte left its page");
    chk_prog_protect: assert property (s_prog_start |->
                                       !$past(prot_hit(page_base | SPAN_PAGE, density, bp)))
        else $error("program started on protected page");
    chk_erase_single: assert property (arr_cmd.valid && arr_cmd.erase
                                       |=> !arr_cmd.valid [*8])
        else $error("erase command repeated");
    chk_byte_bound: assert property (@(posedge sck) disable iff (rst)
                                     armed || bit_cnt != 3'h7 |=> $stable(byte_tgl))
        else $error("byte completed off boundary");

endmodule
`default_nettype wire

// File: flash_seq_pkg.sv
// Constants, types and carriers shared by the program/erase sequencer
`default_nettype none
package flash_seq_pkg;

    // ****************************************
    // Instruction codes
    // ****************************************
    localparam logic [7:0] OPC_PAGE_WRITE  = 8'h02;
    localparam logic [7:0] OPC_SMALL_WIPE  = 8'hd7;
    localparam logic [7:0] OPC_LARGE_WIPE  = 8'hd8;
    localparam logic [7:0] OPC_FULL_WIPE   = 8'hc7;

    // ****************************************
    // Address geometry
    // ****************************************
    localparam int         ADDR_W          = 19;
    localparam logic [2:0] ADDR_BYTES_END  = 3'h4;
    localparam logic [2:0] OPC_ONLY_BYTES  = 3'h1;
    localparam logic [18:0] MASK_512K      = 19'h0ffff;
    localparam logic [18:0] MASK_1M        = 19'h1ffff;
    localparam logic [18:0] MASK_2M        = 19'h3ffff;
    localparam logic [18:0] MASK_4M        = 19'h7ffff;
    localparam logic [18:0] SPAN_PAGE      = 19'h000ff;
    localparam logic [18:0] SPAN_SUBSECTOR = 19'h003ff;
    localparam logic [18:0] SPAN_SECTOR    = 19'h00fff;
    localparam logic [18:0] SPAN_BLOCK_32K = 19'h07fff;
    localparam logic [18:0] SPAN_BLOCK_64K = 19'h0ffff;
    localparam logic [8:0]  PAGE_LAST      = 9'h0ff;

    // ****************************************
    // Reset values
    // ****************************************
    localparam logic       PERMIT_RESET    = 1'b0;
    localparam logic [2:0] SYNC_RESET      = 3'h1;

    // ****************************************
    // Operation times
    // ****************************************
    localparam int TIMER_W        = 22;
    localparam int CLK_MHZ        = 50;
    localparam int PROG_TIME_US   = 2000;
    localparam int ERASE_TIME_US  = 40000;
    localparam int PROG_CYCLES    = PROG_TIME_US * CLK_MHZ;
    localparam int ERASE_CYCLES   = ERASE_TIME_US * CLK_MHZ;

    // ****************************************
    // Types
    // ****************************************
    typedef enum logic [1:0] {
        DENS_512K = 2'h0,
        DENS_1M   = 2'h1,
        DENS_2M   = 2'h2,
        DENS_4M   = 2'h3
    } density_t;

    typedef enum logic [3:0] {
        ST_IDLE  = 4'h1,
        ST_PROG  = 4'h2,
        ST_ERASE = 4'h4,
        ST_WAIT  = 4'h8
    } seq_state_t;

    typedef struct packed {
        logic        valid;
        logic        erase;
        logic [18:0] addr;
        logic [18:0] span;
        logic [7:0]  data;
    } arr_cmd_t;

endpackage
`default_nettype wire

// File: flash_host_model.sv
// Host model that shifts instruction frames into the sequencer
`timescale 1ns/100ps
`default_nettype none
module flash_host_model (
    // Serial link
    output var logic sck,
    output var logic cs_n,
    output var logic si
);
    logic [7:0] tx [$];

    initial
    begin
        sck  = 1'b0;
        cs_n = 1'b1;
        si   = 1'b0;
    end

    // ********
    // Frame: bytes MSB first, then any stray bits
    // ********
    task automatic send(input int extra);
        int n;
        n = tx.size() * 8 + extra;
        cs_n = 1'b0;
        for (int i = 0; i < n; i++)
        begin
            si = (i / 8 < tx.size()) ? tx[i / 8][7 - i % 8] : i[0];
            #15 sck = 1'b1;
            #15 sck = 1'b0;
        end
        #15 cs_n = 1'b1;
        // Released line must not keep showing the last bit
        si = ~si;
        #200;
    endtask
endmodule
`default_nettype wire

// File: flash_seq_tb.sv
// Self-checking bench for the program and erase sequencer
`timescale 1ns/100ps
`default_nettype none
module flash_seq_tb import flash_seq_pkg::*;;
    localparam int PC = 400;
    localparam int EC = 50;
    logic        clk;
    logic        rst;
    logic        sck;
    logic        cs_n;
    logic        si;
    density_t    density;
    logic        subsector_en;
    logic [2:0]  bp;
    logic        latch;
    logic        pending;
    arr_cmd_t    arr_cmd;
    logic [7:0]  mem [0:131071];
    logic [18:0] last_base;
    logic [18:0] last_span;
    int          n_mismatch;
    int          cmp_count;
    logic [7:0]  e_opc [6] = '{OPC_SMALL_WIPE, OPC_SMALL_WIPE, OPC_LARGE_WIPE, OPC_FULL_WIPE,
                               OPC_LARGE_WIPE, OPC_SMALL_WIPE};
    logic [23:0] e_addr [6] = '{24'h060150, 24'hfe3123, 24'h00d555, 24'h000000, 24'h02d555,
                                24'h000150};
    logic [18:0] e_base [6] = '{19'h00000, 19'h03000, 19'h08000, 19'h00000, 19'h20000,
                                19'h00000};
    logic [18:0] e_span [6] = '{SPAN_SUBSECTOR, SPAN_SECTOR, SPAN_BLOCK_32K, MASK_1M,
                                SPAN_BLOCK_64K, SPAN_SECTOR};

    flash_host_model host (.sck(sck), .cs_n(cs_n), .si(si));

    flash_seq #(.PROG_CYC(PC), .ERASE_CYC(EC)) DUT (
        .clk(clk), .rst(rst), .sck(sck), .cs_n(cs_n), .si(si),
        .density(density), .subsector_en(subsector_en),
        .protect_level_bit2(bp[2]), .protect_level_bit1(bp[1]),
        .protect_level_bit0(bp[0]), .write_permit_latch(latch),
        .operation_pending_flag(pending), .arr_cmd(arr_cmd));

    always #10 clk = ~clk;

    // ********
    // Array model fed by the array port
    // ********
    always @(posedge clk)
    begin
        if (arr_cmd.valid === 1'b1)
        begin
            if (arr_cmd.erase)
            begin
                last_base <= arr_cmd.addr;
                last_span <= arr_cmd.span;
                for (int a = 0; a < 131072; a++)
                    if (a >= arr_cmd.addr && a <= (arr_cmd.addr | arr_cmd.span))
                        mem[a] = 8'hff;
            end
            else
                mem[arr_cmd.addr[16:0]] = mem[arr_cmd.addr[16:0]] & arr_cmd.data;
        end
    end

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic print_verdict();
        $display("mismatches %0d comparisons %0d", n_mismatch, cmp_count);
        if (n_mismatch == 0 && cmp_count > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    task automatic wait_pend(input logic val, input int bound);
        int i;
        i = 0;
        while (pending !== val && i < bound)
        begin
            @(negedge clk);
            i++;
        end
        check("pending flag", val, pending);
        if (pending !== val)
            print_verdict();
    endtask

    task automatic run_op(input int n);
        wait_pend(1'b1, 20);
        wait_pend(1'b0, n + 20);
        check("permit latch", 1'b0, latch);
    endtask

    task automatic idle(input string what);
        repeat (30) @(negedge clk);
        check(what, 1'b0, pending);
    endtask

    task automatic start(input logic [7:0] opc, input logic [23:0] a, input int na);
        host.tx = {opc};
        for (int i = 0; i < na; i++)
            host.tx.push_back(a[23 - 8 * i -: 8]);
    endtask

    task automatic permit();
        host.tx = {8'h06};
        host.send(0);
        check("permit latch", 1'b1, latch);
    endtask

    // ********
    // Main sequence
    // ********
    initial
    begin
        clk = 1'b0;
        rst = 1'b1;
        density = DENS_1M;
        subsector_en = 1'b1;
        bp = 3'h0;
        n_mismatch = 0;
        cmp_count = 0;
        foreach (mem[a])
            mem[a] = 8'hff;
        repeat (10) @(negedge clk);
        rst = 1'b0;
        @(negedge clk);
        check("permit latch", 1'b0, latch);
        check("pending flag", 1'b0, pending);
        start(OPC_PAGE_WRITE, 24'h000100, 3);
        host.tx.push_back(8'h00);
        host.send(0);
        idle("write without permit");
        permit();
        start(OPC_PAGE_WRITE, 24'h0001fe, 3);
        host.tx.push_back(8'ha5);
        host.tx.push_back(8'h3c);
        host.tx.push_back(8'h0f);
        host.send(0);
        run_op(PC);
        check("byte 1fe", 8'ha5, mem[17'h001fe]);
        check("byte 1ff", 8'h3c, mem[17'h001ff]);
        check("byte 100", 8'h0f, mem[17'h00100]);
        check("byte 101", 8'hff, mem[17'h00101]);
        permit();
        start(OPC_PAGE_WRITE, 24'h000100, 3);
        host.tx.push_back(8'hf0);
        host.send(0);
        run_op(PC);
        check("byte 100", 8'h00, mem[17'h00100]);
        permit();
        start(OPC_PAGE_WRITE, 24'h000400, 3);
        for (int i = 0; i < 258; i++)
            host.tx.push_back(i[8:1]);
        host.send(0);
        start(OPC_PAGE_WRITE, 24'h000500, 3);
        host.tx.push_back(8'h00);
        host.send(0);
        run_op(PC);
        check("byte 400", 8'h80, mem[17'h00400]);
        check("byte 401", 8'h80, mem[17'h00401]);
        check("byte 402", 8'h01, mem[17'h00402]);
        check("byte 4ff", 8'h7f, mem[17'h004ff]);
        check("byte 500", 8'hff, mem[17'h00500]);
        permit();
        start(OPC_PAGE_WRITE, 24'h000600, 3);
        host.tx.push_back(8'h00);
        host.send(3);
        idle("partial byte");
        start(OPC_PAGE_WRITE, 24'h000600, 2);
        host.send(0);
        idle("short address");
        check("permit latch", 1'b1, latch);
        for (int j = 0; j < 2; j++)
        begin
            @(negedge clk);
            bp = j ? 3'h6 : 3'h1;
            start(OPC_PAGE_WRITE, j ? 24'h010000 : 24'h01ff00, 3);
            host.tx.push_back(8'h00);
            host.send(0);
            idle("protected write");
            check("protected byte", 8'hff, mem[j ? 17'h10000 : 17'h1ff00]);
        end
        host.tx = {8'h04};
        host.send(0);
        check("permit latch", 1'b0, latch);
        @(negedge clk);
        bp = 3'h0;
        for (int k = 0; k < 6; k++)
        begin
            if (k == 4)
                density = DENS_2M;
            subsector_en = (k != 5);
            permit();
            start(e_opc[k], e_addr[k], (k == 3) ? 0 : 3);
            host.send(0);
            if (k == 1)
            begin
                host.tx = {8'h04};
                host.send(0);
                check("permit latch", 1'b1, latch);
            end
            run_op(EC);
            check("wipe base", e_base[k], last_base);
            check("wipe span", e_span[k], last_span);
            if (k == 0)
            begin
                check("byte 100", 8'hff, mem[17'h00100]);
                check("byte 400", 8'h80, mem[17'h00400]);
            end
        end
        print_verdict();
    end
endmodule
`default_nettype wire
